// file: pkt_match_pkg.sv
// Purpose: shared codes for the link packet class and opcode matcher
// Assumes: 4-bit class and 4-bit opcode fields per link packet
// Notes: decode kinds are shared where two classes carry the same meaning
// How it works
// - class field names seven classes, 0011 empty
// - software picks class and opcode to count
// - request opcodes decode to nine read/invalidate kinds
// - snoop 0-5 plain, 8-13 same kinds fanout
// - non-data response opcodes decode to eleven kinds
// - data responses, ordered, implicit writeback, debug data
// - writeback class opcodes decode to eleven kinds
// - non-coherent bypass opcodes decode to nine kinds
// - non-coherent standard opcodes decode to eleven kinds
package pkt_match_pkg;
    localparam int CLASS_W = 4;
    localparam int OPC_W = 4;

    // message class codes
    localparam logic [CLASS_W-1:0] CLASS_REQUEST = 4'h0;
    localparam logic [CLASS_W-1:0] CLASS_SNOOP = 4'h1;
    localparam logic [CLASS_W-1:0] CLASS_NONDATA_RESP = 4'h2;
    localparam logic [CLASS_W-1:0] CLASS_EMPTY = 4'h3;
    localparam logic [CLASS_W-1:0] CLASS_DATA_RESP = 4'h4;
    localparam logic [CLASS_W-1:0] CLASS_WRITEBACK = 4'h5;
    localparam logic [CLASS_W-1:0] CLASS_NC_BYPASS = 4'h6;
    localparam logic [CLASS_W-1:0] CLASS_NC_STANDARD = 4'h7;

    // reset values of registered outputs
    localparam logic [CLASS_W-1:0] CLASS_RESET = 4'h0;
    localparam logic [OPC_W-1:0] OPC_RESET = 4'h0;

    // how the comparator selects packets
    typedef enum logic [1:0] {
        MODE_CLASS_OPCODE = 2'h0,
        MODE_CLASS_ONLY = 2'h1,
        MODE_KIND = 2'h2,
        MODE_OFF = 2'h3
    } match_mode_t;

    // decoded packet kinds
    typedef enum logic [6:0] {
        K_NONE, K_RESERVED,
        K_READ_CURRENT, K_READ_CODE, K_READ_DATA, K_READ_DATA_MIGR, K_READ_INVAL_OWN,
        K_FLUSH_ALL, K_INVAL_TO_EXCL, K_READ_INVAL, K_INVAL_TO_MOD,
        K_SNOOP_CURRENT, K_SNOOP_CODE, K_SNOOP_DATA, K_SNOOP_MIGR, K_SNOOP_INVAL_OWN,
        K_SNOOP_INVAL,
        K_CMP_UNORDERED, K_CMP_PEER, K_RESP_INVALID, K_RESP_SHARED, K_RESP_FWD,
        K_RESP_FWD_INVALID, K_RESP_FWD_SHARED, K_CMP_MIRROR, K_RESP_CONFLICT,
        K_CMP_ORDERED, K_FWD_CONFLICT,
        K_DATA_MOD, K_DATA_EXCL, K_DATA_SHARED, K_DATA_MOD_CMP, K_DATA_EXCL_CMP,
        K_DATA_SHARED_CMP, K_IWRBK_FWD_INVALID, K_IWRBK_FWD_SHARED, K_IWRBK_INVALID,
        K_IWRBK_SHARED, K_DEBUG_DATA,
        K_WRBK_TO_INVALID, K_WRBK_TO_SHARED, K_WRBK_TO_EXCL, K_NONSNOOP_WRITE,
        K_WRBK_PART_INVALID, K_WRBK_PART_EXCL, K_NONSNOOP_WRITE_PART, K_WRBK_PUSH,
        K_FLUSH_HINT, K_CLEAN_EVICT, K_NONSNOOP_READ,
        K_NC_WRITE, K_WC_WRITE, K_NC_MESSAGE, K_INT_LOGICAL, K_INT_PHYSICAL,
        K_INT_PRIO_UPDATE, K_NC_WRITE_PART, K_WC_WRITE_PART, K_PEER_TO_PEER,
        K_NC_READ, K_INT_ACK, K_NC_READ_PART, K_CFG_READ, K_LOCKED_READ, K_IO_READ,
        K_CFG_WRITE, K_LOCKED_WRITE, K_IO_WRITE
    } kind_t;

    typedef struct packed {
        logic reserved;
        logic fanout;
        kind_t kind;
    } decode_t;
endpackage

// file: select_compare.sv
// Purpose: registered match strobe against the software selection
// Assumes: inputs come from logic on sys_clk
// Notes: one cycle from packet to match
`timescale 1ns/1ns
module select_compare
    import pkt_match_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic clk_en, // freezes state when low
    input wire logic pkt_valid, // packet present this cycle
    input wire logic [CLASS_W-1:0] pkt_class, // packet class field
    input wire logic [OPC_W-1:0] pkt_opcode, // packet opcode field
    input wire kind_t pkt_kind, // decoded kind of the packet
    input wire logic pkt_reserved, // packet kind is reserved
    input wire match_mode_t sel_mode, // selection mode
    input wire logic [CLASS_W-1:0] sel_class, // selected class
    input wire logic [OPC_W-1:0] sel_opcode, // selected opcode
    input wire kind_t sel_kind, // selected kind
    output logic match // one-cycle match strobe
);
    logic next_match;

    // selection against class and opcode, class alone, or by named kind
    always_comb
    begin
        next_match = 1'b0;
        if (pkt_valid)
        begin
            case (sel_mode)
                MODE_CLASS_OPCODE: next_match = (pkt_class == sel_class)
                    && (pkt_opcode == sel_opcode);
                MODE_CLASS_ONLY: next_match = (pkt_class == sel_class);
                MODE_KIND: next_match = (pkt_kind == sel_kind) && !pkt_reserved;
                default: next_match = 1'b0;
            endcase
        end
    end

    // match register
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            match <= 1'b0;
        else if (clk_en)
            match <= next_match;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence exact_hit;
        clk_en && pkt_valid && sel_mode == MODE_CLASS_OPCODE
            && pkt_class == sel_class && pkt_opcode == sel_opcode;
    endsequence

    sequence class_miss;
        clk_en && pkt_valid && sel_mode == MODE_CLASS_OPCODE && pkt_class != sel_class;
    endsequence

    select_match_a: assert property (exact_hit |=> match)
        else $error("selected class and opcode did not match");
    class_mismatch_a: assert property (class_miss |=> !match)
        else $error("match raised for another class");
    idle_no_match_a: assert property (clk_en && !pkt_valid |=> !match)
        else $error("match without a packet");
endmodule

// file: link_packet_class_opcode_matcher.sv
// Purpose: decode link packet class and opcode, flag selected traffic
// Assumes: packet fields and selection come from logic on sys_clk
// Notes: all outputs registered, one cycle after the packet
`timescale 1ns/1ns
module link_packet_class_opcode_matcher
    import pkt_match_pkg::*;
(
    input wire logic sys_clk, // system clock, 100 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic clk_en, // freezes state when low
    input wire logic pkt_valid, // packet present this cycle
    input wire logic [CLASS_W-1:0] pkt_class, // packet class field
    input wire logic [OPC_W-1:0] pkt_opcode, // packet opcode field
    input wire match_mode_t sel_mode, // selection mode
    input wire logic [CLASS_W-1:0] sel_class, // selected class
    input wire logic [OPC_W-1:0] sel_opcode, // selected opcode
    input wire kind_t sel_kind, // selected kind
    output logic match, // one-cycle match strobe
    output logic kind_valid, // decoded fields below are fresh
    output kind_t kind, // decoded kind
    output logic [CLASS_W-1:0] kind_class, // class of decoded packet
    output logic [OPC_W-1:0] kind_opcode, // opcode of decoded packet
    output logic kind_reserved, // class or opcode unassigned
    output logic kind_fanout // snoop goes to all peers
);
    decode_t next_decode;

    // table walk from class and opcode to a packet kind
    function automatic decode_t decode_packet(
        input logic [CLASS_W-1:0] cls,
        input logic [OPC_W-1:0] opc
    );
        decode_t d;
        d.reserved = 1'b0;
        d.fanout = 1'b0;
        d.kind = K_RESERVED;
        if (cls == CLASS_REQUEST)
        begin
            case (opc)
                4'h0: d.kind = K_READ_CURRENT;
                4'h1: d.kind = K_READ_CODE;
                4'h2: d.kind = K_READ_DATA;
                4'h3: d.kind = K_READ_DATA_MIGR;
                4'h4: d.kind = K_READ_INVAL_OWN;
                4'h5: d.kind = K_FLUSH_ALL;
                4'h7: d.kind = K_INVAL_TO_EXCL;
                4'hC: d.kind = K_READ_INVAL;
                4'hF: d.kind = K_INVAL_TO_MOD;
                default: d.reserved = 1'b1;
            endcase
        end
        else if (cls == CLASS_SNOOP)
        begin
            d.fanout = opc[3];
            case (opc)
                4'h0, 4'h8: d.kind = K_SNOOP_CURRENT;
                4'h1, 4'h9: d.kind = K_SNOOP_CODE;
                4'h2, 4'hA: d.kind = K_SNOOP_DATA;
                4'h3, 4'hB: d.kind = K_SNOOP_MIGR;
                4'h4, 4'hC: d.kind = K_SNOOP_INVAL_OWN;
                4'h5, 4'hD: d.kind = K_SNOOP_INVAL;
                default:
                begin
                    d.reserved = 1'b1;
                    d.fanout = 1'b0;
                end
            endcase
        end
        else if (cls == CLASS_NONDATA_RESP)
        begin
            case (opc)
                4'h0: d.kind = K_CMP_UNORDERED;
                4'h1: d.kind = K_CMP_PEER;
                4'h2: d.kind = K_RESP_INVALID;
                4'h3: d.kind = K_RESP_SHARED;
                4'h4: d.kind = K_RESP_FWD;
                4'h5: d.kind = K_RESP_FWD_INVALID;
                4'h6: d.kind = K_RESP_FWD_SHARED;
                4'h8: d.kind = K_CMP_MIRROR;
                4'hA: d.kind = K_RESP_CONFLICT;
                4'hC: d.kind = K_CMP_ORDERED;
                4'hD: d.kind = K_FWD_CONFLICT;
                default: d.reserved = 1'b1;
            endcase
        end
        else if (cls == CLASS_DATA_RESP)
        begin
            case (opc)
                4'h0: d.kind = K_DATA_MOD;
                4'h1: d.kind = K_DATA_EXCL;
                4'h2: d.kind = K_DATA_SHARED;
                4'h4: d.kind = K_DATA_MOD_CMP;
                4'h5: d.kind = K_DATA_EXCL_CMP;
                4'h6: d.kind = K_DATA_SHARED_CMP;
                4'hA: d.kind = K_IWRBK_FWD_INVALID;
                4'hB: d.kind = K_IWRBK_FWD_SHARED;
                4'hC: d.kind = K_IWRBK_INVALID;
                4'hD: d.kind = K_IWRBK_SHARED;
                4'hF: d.kind = K_DEBUG_DATA;
                default: d.reserved = 1'b1;
            endcase
        end
        else if (cls == CLASS_WRITEBACK)
        begin
            case (opc)
                4'h0: d.kind = K_WRBK_TO_INVALID;
                4'h1: d.kind = K_WRBK_TO_SHARED;
                4'h2: d.kind = K_WRBK_TO_EXCL;
                4'h3: d.kind = K_NONSNOOP_WRITE;
                4'h4: d.kind = K_WRBK_PART_INVALID;
                4'h6: d.kind = K_WRBK_PART_EXCL;
                4'h7: d.kind = K_NONSNOOP_WRITE_PART;
                4'h8: d.kind = K_WRBK_PUSH;
                4'hB: d.kind = K_FLUSH_HINT;
                4'hC: d.kind = K_CLEAN_EVICT;
                4'hD: d.kind = K_NONSNOOP_READ;
                default: d.reserved = 1'b1;
            endcase
        end
        else if (cls == CLASS_NC_BYPASS)
        begin
            case (opc)
                4'h0: d.kind = K_NC_WRITE;
                4'h1: d.kind = K_WC_WRITE;
                4'h8: d.kind = K_NC_MESSAGE;
                4'h9: d.kind = K_INT_LOGICAL;
                4'hA: d.kind = K_INT_PHYSICAL;
                4'hB: d.kind = K_INT_PRIO_UPDATE;
                4'hC: d.kind = K_NC_WRITE_PART;
                4'hD: d.kind = K_WC_WRITE_PART;
                4'hF: d.kind = K_PEER_TO_PEER;
                default: d.reserved = 1'b1;
            endcase
        end
        else if (cls == CLASS_NC_STANDARD)
        begin
            case (opc)
                4'h0: d.kind = K_NC_READ;
                4'h1: d.kind = K_INT_ACK;
                4'h4: d.kind = K_NC_READ_PART;
                4'h5: d.kind = K_CFG_READ;
                4'h6: d.kind = K_LOCKED_READ;
                4'h7: d.kind = K_IO_READ;
                4'h8: d.kind = K_NC_MESSAGE;
                4'h9: d.kind = K_CFG_WRITE;
                4'hA: d.kind = K_LOCKED_WRITE;
                4'hB: d.kind = K_IO_WRITE;
                4'hF: d.kind = K_PEER_TO_PEER;
                default: d.reserved = 1'b1;
            endcase
        end
        else
        begin
            d.reserved = 1'b1; // 0011 and codes above 0111 carry no class
        end
        return d;
    endfunction

    // decode of the current packet
    always_comb
    begin
        next_decode = decode_packet(pkt_class, pkt_opcode);
    end

    // decoded fields, held between packets
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            kind <= K_NONE;
            kind_class <= CLASS_RESET;
            kind_opcode <= OPC_RESET;
            kind_reserved <= 1'b0;
            kind_fanout <= 1'b0;
        end
        else if (clk_en && pkt_valid)
        begin
            kind <= next_decode.kind;
            kind_class <= pkt_class;
            kind_opcode <= pkt_opcode;
            kind_reserved <= next_decode.reserved;
            kind_fanout <= next_decode.fanout;
        end
    end

    // freshness strobe for the decoded fields
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            kind_valid <= 1'b0;
        else if (clk_en)
            kind_valid <= pkt_valid;
    end

    // selection comparator with its own output register
    select_compare u_compare (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .pkt_valid(pkt_valid),
        .pkt_class(pkt_class),
        .pkt_opcode(pkt_opcode),
        .pkt_kind(next_decode.kind),
        .pkt_reserved(next_decode.reserved),
        .sel_mode(sel_mode),
        .sel_class(sel_class),
        .sel_opcode(sel_opcode),
        .sel_kind(sel_kind),
        .match(match)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence took(logic [CLASS_W-1:0] c, logic [OPC_W-1:0] o);
        clk_en && pkt_valid && pkt_class == c && pkt_opcode == o;
    endsequence

    class_decode_a: assert property (took(CLASS_EMPTY, OPC_RESET) |=> kind_reserved)
        else $error("empty class not flagged reserved");
    req_decode_a: assert property (took(CLASS_REQUEST, 4'h5) |=> kind == K_FLUSH_ALL)
        else $error("request flush opcode misdecoded");
    snoop_fanout_a: assert property (took(CLASS_SNOOP, 4'hD)
        |=> kind == K_SNOOP_INVAL && kind_fanout && !kind_reserved)
        else $error("fanout snoop misdecoded");
    nondata_decode_a: assert property (took(CLASS_NONDATA_RESP, 4'hA)
        |=> kind == K_RESP_CONFLICT)
        else $error("conflict response misdecoded");
    data_decode_a: assert property (took(CLASS_DATA_RESP, 4'hF)
        |=> kind == K_DEBUG_DATA)
        else $error("debug data misdecoded");
    wrback_decode_a: assert property (took(CLASS_WRITEBACK, 4'hB)
        |=> kind == K_FLUSH_HINT)
        else $error("flush hint misdecoded");
    bypass_decode_a: assert property (took(CLASS_NC_BYPASS, 4'h9)
        |=> kind == K_INT_LOGICAL)
        else $error("logical interrupt misdecoded");
    standard_decode_a: assert property (took(CLASS_NC_STANDARD, 4'h9)
        |=> kind == K_CFG_WRITE && kind_class == CLASS_NC_STANDARD)
        else $error("configuration write misdecoded");
    gap_reserved_a: assert property (took(CLASS_REQUEST, 4'h6)
        |=> kind_reserved && kind_valid)
        else $error("unassigned request opcode not reserved");
endmodule

// file: link_tx_model.sv
// Purpose: far-side link layer logic that presents packets to the matcher
// Assumes: requests change just after a rising edge, one packet per request
// Notes: idle fields show the inverse of the last value, so stale data never matches by luck
`timescale 1ns/1ns
module link_tx_model
    import pkt_match_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic req_send, // present a packet at the next falling edge
    input wire logic [CLASS_W-1:0] req_class, // class to send
    input wire logic [OPC_W-1:0] req_opcode, // opcode to send
    output logic pkt_valid, // packet present
    output logic [CLASS_W-1:0] pkt_class, // class field
    output logic [OPC_W-1:0] pkt_opcode // opcode field
);
    // packets launch on the falling edge, half a cycle before the matcher samples
    always @(negedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pkt_valid <= 1'b0;
            pkt_class <= 4'h3;
            pkt_opcode <= 4'hE;
        end
        else if (req_send)
        begin
            pkt_valid <= 1'b1;
            pkt_class <= req_class;
            pkt_opcode <= req_opcode;
        end
        else
        begin
            pkt_valid <= 1'b0;
            pkt_class <= ~pkt_class; // released fields keep moving
            pkt_opcode <= ~pkt_opcode;
        end
    end
endmodule

// file: tb_top.sv
// Purpose: self-checking bench for the link packet class and opcode matcher
// Assumes: one packet per cycle at most, selection changes with the packet
// Notes: expected decode is built from per-class masks of assigned opcodes
`timescale 1ns/1ns
module tb_top
    import pkt_match_pkg::*;
;
    logic sys_clk, rst_b, clk_en, req_send, pkt_valid, match, kind_valid;
    logic kind_reserved, kind_fanout, e_match, e_kv;
    logic [3:0] req_class, req_opcode, pkt_class, pkt_opcode, sel_class, sel_opcode;
    logic [3:0] kind_class, kind_opcode, e_cls, e_opc, c;
    match_mode_t sel_mode;
    kind_t sel_kind, kind;
    decode_t e_dec, d;
    logic [31:0] r;
    int bad_count, checks_done;

    link_tx_model tx_u (.sys_clk(sys_clk), .rst_b(rst_b), .req_send(req_send),
        .req_class(req_class), .req_opcode(req_opcode), .pkt_valid(pkt_valid),
        .pkt_class(pkt_class), .pkt_opcode(pkt_opcode));
    link_packet_class_opcode_matcher dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_en(clk_en), .pkt_valid(pkt_valid), .pkt_class(pkt_class),
        .pkt_opcode(pkt_opcode), .sel_mode(sel_mode), .sel_class(sel_class),
        .sel_opcode(sel_opcode), .sel_kind(sel_kind), .match(match),
        .kind_valid(kind_valid), .kind(kind), .kind_class(kind_class),
        .kind_opcode(kind_opcode), .kind_reserved(kind_reserved), .kind_fanout(kind_fanout));

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    // expected decode: kind is the class base plus the count of assigned codes below it
    function automatic decode_t exp_decode(input logic [3:0] ec, input logic [3:0] o);
        logic [15:0] full;
        logic [15:0] part;
        logic [6:0] base;
        logic [3:0] idx;
        decode_t x;
        int n;
        full = 16'h0000;
        base = 7'h00;
        case (ec)
            CLASS_REQUEST: {full, base} = {16'h90BF, 7'(K_READ_CURRENT)};
            CLASS_SNOOP: {full, base} = {16'h3F3F, 7'(K_SNOOP_CURRENT)};
            CLASS_NONDATA_RESP: {full, base} = {16'h357F, 7'(K_CMP_UNORDERED)};
            CLASS_DATA_RESP: {full, base} = {16'hBC77, 7'(K_DATA_MOD)};
            CLASS_WRITEBACK: {full, base} = {16'h39DF, 7'(K_WRBK_TO_INVALID)};
            CLASS_NC_BYPASS: {full, base} = {16'hBF03, 7'(K_NC_WRITE)};
            CLASS_NC_STANDARD: {full, base} = {16'h8FF3, 7'(K_NC_READ)};
            default: full = 16'h0000;
        endcase
        part = (ec == CLASS_NC_STANDARD) ? 16'h0EF3 : full; // shared kinds left out
        idx = (ec == CLASS_SNOOP) ? {1'b0, o[2:0]} : o; // fanout reuses plain kinds
        n = 0;
        for (int i = 0; i < 16; i++)
            n += ((i < idx) && part[i]) ? 1 : 0;
        x.reserved = !full[o];
        x.fanout = (ec == CLASS_SNOOP) && o[3] && full[o];
        x.kind = kind_t'(base + 7'(n));
        if (ec == CLASS_NC_STANDARD && o == 4'h8)
            x.kind = K_NC_MESSAGE;
        if (ec == CLASS_NC_STANDARD && o == 4'hF)
            x.kind = K_PEER_TO_PEER;
        if (x.reserved)
            x.kind = K_RESERVED; // unassigned codes carry no kind of their own
        return x;
    endfunction

    // expected match for one packet under one selection
    function automatic logic exp_hit(input logic [3:0] ec, input logic [3:0] o,
        input decode_t x, input match_mode_t m, input logic [3:0] sc,
        input logic [3:0] so, input kind_t sk);
        case (m)
            MODE_CLASS_OPCODE: return ec == sc && o == so;
            MODE_CLASS_ONLY: return ec == sc;
            MODE_KIND: return !x.reserved && x.kind == sk;
            default: return 1'b0;
        endcase
    endfunction

    task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic compare();
        chk(7'(match), 7'(e_match));
        chk(7'(kind_valid), 7'(e_kv));
        chk(7'(kind_class), 7'(e_cls));
        chk(7'(kind_opcode), 7'(e_opc));
        chk(7'(kind_reserved), 7'(e_dec.reserved));
        chk(7'(kind_fanout), 7'(e_dec.fanout));
        chk(7'(kind), 7'(e_dec.kind));
    endtask

    task automatic do_reset();
        @(negedge sys_clk);
        rst_b = 1'b0;
        req_send = 1'b0;
        e_match = 1'b0;
        e_kv = 1'b0;
        e_dec = '{1'b0, 1'b0, K_NONE};
        e_cls = 4'h0;
        e_opc = 4'h0;
        repeat (20) @(negedge sys_clk);
        compare();
        rst_b = 1'b1;
    endtask

    // one cycle: check the last packet's answer, then launch the next one
    task automatic step(input logic v, input logic [3:0] ec, input logic [3:0] o,
        input match_mode_t m, input logic [3:0] sc, input logic [3:0] so,
        input kind_t sk, input logic en);
        decode_t x;
        @(posedge sys_clk);
        #1;
        req_send = v;
        req_class = ec;
        req_opcode = o;
        @(negedge sys_clk);
        compare();
        sel_mode <= m;
        sel_class <= sc;
        sel_opcode <= so;
        sel_kind <= sk;
        clk_en <= en;
        x = exp_decode(ec, o);
        if (en)
        begin
            e_match = v && exp_hit(ec, o, x, m, sc, so, sk);
            e_kv = v;
            if (v)
            begin
                e_dec = x;
                e_cls = ec;
                e_opc = o;
            end
        end
    endtask

    task automatic final_report();
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // main sequence: code sweeps, cross-class opcodes, random traffic, mid-run reset
    initial
    begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        {req_send, req_class, req_opcode, sel_class, sel_opcode} = '0;
        sel_mode = MODE_OFF;
        sel_kind = K_NONE;
        bad_count = 0;
        checks_done = 0;
        r = $urandom(32'h2b34626f);
        do_reset();
        for (int i = 0; i < 256; i++)
            step(1'b1, i[7:4], i[3:0], MODE_CLASS_OPCODE, i[7:4], i[3:0], K_NONE, 1'b1);
        for (int i = 0; i < 256; i++)
        begin
            d = exp_decode(i[7:4], i[3:0]);
            step(1'b1, i[7:4], i[3:0], MODE_KIND, 4'h0, 4'h0, d.kind, 1'b1);
        end
        for (int i = 0; i < 128; i++)
            step(1'b1, i[7:4], i[3:0], MODE_CLASS_OPCODE, i[7:4] + 4'h1, i[3:0], K_NONE, 1'b1);
        for (int i = 0; i < 3000; i++)
        begin
            r = $urandom;
            c = r[20] ? {1'b0, r[2:0]} : r[3:0];
            d = exp_decode(c, r[11:8]);
            step(r[4], c, r[11:8], match_mode_t'(r[13:12]), r[14] ? c : r[19:16],
                r[15] ? r[11:8] : r[27:24], r[22] ? d.kind : kind_t'(r[30:24] % 7'd68),
                r[31] | r[21]);
        end
        do_reset();
        step(1'b1, CLASS_SNOOP, 4'hD, MODE_CLASS_OPCODE, CLASS_SNOOP, 4'hD, K_NONE, 1'b1);
        step(1'b0, 4'h0, 4'h0, MODE_OFF, 4'h0, 4'h0, K_NONE, 1'b1);
        step(1'b0, 4'h0, 4'h0, MODE_OFF, 4'h0, 4'h0, K_NONE, 1'b1);
        final_report();
    end
endmodule
